/* ext_bus_pkg.sv */
// constants for the shared external bus port
// assumes a single 250 MHz clock domain, no software registers
package ext_bus_pkg;
  localparam int ADDR_W        = 32;
  localparam int DATA_W        = 48;
  localparam int BANKS         = 4;
  localparam int WORD32_LO     = 16;   // 32-bit words on 47..16
  localparam int WORD40_LO     = 8;    // 40-bit words on 47..8
  localparam int SHORT_LO      = 16;   // short words on 31..16
  localparam int SHORT_HI      = 31;
  localparam int BYTE_LO       = 16;   // boot bytes on 23..16
  localparam int BYTE_HI       = 23;
  localparam int BANK_SZ_W     = 5;    // log2 of bank size in words
  localparam int PAGE_SZ_W     = 5;    // log2 of page size in words
  localparam logic [BANK_SZ_W-1:0] BANK_SZ_RST = 5'h0D;
  localparam logic [PAGE_SZ_W-1:0] PAGE_SZ_RST = 5'h08;
  localparam logic [BANKS-1:0] SEL_IDLE = 4'hF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 48'h0000_0000_0000;

  // data formats on the bus
  typedef enum logic [2:0] {
    FMT_WORD48 = 3'h0,
    FMT_WORD32 = 3'h1,
    FMT_WORD40 = 3'h2,
    FMT_SHORT  = 3'h3,
    FMT_BYTE   = 3'h4
  } fmt_t;

  // master state machine, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ADDR  = 4'h2,
    ST_DATA  = 4'h4,
    ST_STALL = 4'h8
  } state_t;
endpackage : ext_bus_pkg

/* bank_decode.sv */
// bank select and page crossing decode from an address
// assumes bank size and page size are held stable by the caller
`timescale 1ns/10ps
module bank_decode (
  input  wire logic [31:0] addr,
  input  wire logic [4:0]  bank_size_log2,
  input  wire logic [4:0]  page_size_log2,
  input  wire logic [31:0] last_addr,
  input  wire logic        last_valid,
  output logic      [3:0]  next_sel_n,
  output logic             next_page_cross
);
  logic [31:0] bank_idx;
  logic [31:0] page_now;
  logic [31:0] page_old;

  // bank index from programmed boundary; above bank 3 means no select
  assign bank_idx = addr >> bank_size_log2;
  assign page_now = addr >> page_size_log2;
  assign page_old = last_addr >> page_size_log2;

  genvar b;
  generate
    for (b = 0; b < ext_bus_pkg::BANKS; b++) begin : g_sel
      assign next_sel_n[b] = (bank_idx != b);
    end
  endgenerate

  // page pulse only for bank zero
  assign next_page_cross = (bank_idx == ext_bus_pkg::ADDR_ZERO) && last_valid && (page_now != page_old);
endmodule : bank_decode

/* shared_external_bus_port.sv */
// shared external bus port: master drive and slave accept of the parallel bus
// assumes all pins synchronous to ref_clk; pad logic resolves enables
`timescale 1ns/10ps
module shared_external_bus_port (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // setup from system_setup_reg and memory control
  input  wire logic [4:0]  bank_size_log2,
  input  wire logic [4:0]  page_size_log2,
  input  wire logic        is_bus_master,
  // core access request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_cond_false,
  input  wire logic [31:0] req_addr,
  input  wire logic [47:0] req_wdata,
  input  wire logic [2:0]  req_fmt,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic      [47:0] rsp_rdata,
  // slave side toward internal memory
  output logic             slv_rd,
  output logic      [31:0] slv_addr,
  // pins
  input  wire logic        bus_float_request_n,
  input  wire logic [31:0] addr_in,
  output logic      [31:0] addr_out,
  output logic             addr_oe,
  input  wire logic [47:0] data_in,
  output logic      [47:0] data_out,
  output logic             data_oe,
  output logic      [3:0]  bank_select_n,
  output logic             bank_select_oe,
  input  wire logic        rd_n_in,
  output logic             rd_n_out,
  output logic             rd_n_oe,
  output logic             page_cross,
  output logic             page_oe
);
  logic [1:0]  rst_sync;
  logic        rst_n_int;
  ext_bus_pkg::state_t state;
  ext_bus_pkg::state_t next_state;
  logic [31:0] last_addr;
  logic        last_valid;
  logic [2:0]  cur_fmt;
  logic        cur_write;
  logic        cur_cond_false;
  logic        rd_in_d;

  // decode results from the address
  wire  [3:0]  dec_sel_n;
  wire         dec_page;

  // sequencing nets
  wire         floating;
  wire         take_req;
  wire         pin_drive;
  wire         go_idle;
  wire         data_cycle;
  wire         read_done;

  // format decode nets
  wire         wr_word32;
  wire         wr_word40;
  wire         wr_short;
  wire         wr_byte;
  wire         rd_word32;
  wire         rd_word40;
  wire         rd_short;
  wire         rd_byte;

  // lane placement nets
  wire  [47:0] wr_lanes_32;
  wire  [47:0] wr_lanes_40;
  wire  [47:0] wr_lanes_16;
  wire  [47:0] wr_lanes_8;
  wire  [47:0] rd_lanes_32;
  wire  [47:0] rd_lanes_40;
  wire  [47:0] rd_lanes_16;
  wire  [47:0] rd_lanes_8;
  wire  [47:0] wdata_lanes;
  wire  [47:0] rdata_lanes;

  // slave side strobe
  wire         slave_read;

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync[1];

  bank_decode u_bank_decode (
    .addr            (req_addr),
    .bank_size_log2  (bank_size_log2),
    .page_size_log2  (page_size_log2),
    .last_addr       (last_addr),
    .last_valid      (last_valid),
    .next_sel_n      (dec_sel_n),
    .next_page_cross (dec_page)
  );

  // float, drive permission and request take
  assign floating  = !bus_float_request_n;
  assign pin_drive = is_bus_master && !floating;
  // ready is the handshake: no take before it is shown
  assign take_req  = req_valid && req_ready && (state == ext_bus_pkg::ST_IDLE) && pin_drive;

  // phases of the running access
  assign go_idle    = (next_state == ext_bus_pkg::ST_IDLE);
  assign data_cycle = (state == ext_bus_pkg::ST_DATA);
  assign read_done  = data_cycle && !cur_write && !cur_cond_false;

  // format of the incoming request
  assign wr_word32 = (req_fmt == ext_bus_pkg::FMT_WORD32);
  assign wr_word40 = (req_fmt == ext_bus_pkg::FMT_WORD40);
  assign wr_short  = (req_fmt == ext_bus_pkg::FMT_SHORT);
  assign wr_byte   = (req_fmt == ext_bus_pkg::FMT_BYTE);

  // format of the access in flight
  assign rd_word32 = (cur_fmt == ext_bus_pkg::FMT_WORD32);
  assign rd_word40 = (cur_fmt == ext_bus_pkg::FMT_WORD40);
  assign rd_short  = (cur_fmt == ext_bus_pkg::FMT_SHORT);
  assign rd_byte   = (cur_fmt == ext_bus_pkg::FMT_BYTE);

  // write lane placement per format
  assign wr_lanes_32 = {req_wdata[31:0], 16'h0000};
  assign wr_lanes_40 = {req_wdata[39:0], 8'h00};
  assign wr_lanes_16 = {16'h0000, req_wdata[15:0], 16'h0000};
  assign wr_lanes_8  = {24'h000000, req_wdata[7:0], 16'h0000};
  assign wdata_lanes =
    wr_word32 ? wr_lanes_32 :
    wr_word40 ? wr_lanes_40 :
    wr_short  ? wr_lanes_16 :
    wr_byte   ? wr_lanes_8  :
    req_wdata;

  // read lane extraction, unused lanes dropped
  assign rd_lanes_32 = {16'h0000, data_in[47:ext_bus_pkg::WORD32_LO]};
  assign rd_lanes_40 = {8'h00, data_in[47:ext_bus_pkg::WORD40_LO]};
  assign rd_lanes_16 = {32'h0000_0000, data_in[ext_bus_pkg::SHORT_HI:ext_bus_pkg::SHORT_LO]};
  assign rd_lanes_8  = {40'h00_0000_0000, data_in[ext_bus_pkg::BYTE_HI:ext_bus_pkg::BYTE_LO]};
  assign rdata_lanes =
    rd_word32 ? rd_lanes_32 :
    rd_word40 ? rd_lanes_40 :
    rd_short  ? rd_lanes_16 :
    rd_byte   ? rd_lanes_8  :
    data_in;

  // slave read strobe from outside master
  assign slave_read = !is_bus_master && !rd_n_in;

  // next state of the master sequence
  always_comb begin
    next_state = state;
    case (state)
      ext_bus_pkg::ST_IDLE: begin
        if (take_req) begin
          next_state = ext_bus_pkg::ST_ADDR;
        end
      end
      ext_bus_pkg::ST_ADDR: begin
        next_state = floating ? ext_bus_pkg::ST_STALL : ext_bus_pkg::ST_DATA;
      end
      ext_bus_pkg::ST_DATA: begin
        next_state = ext_bus_pkg::ST_IDLE;
      end
      ext_bus_pkg::ST_STALL: begin
        if (!floating) begin
          next_state = ext_bus_pkg::ST_ADDR;
        end
      end
      default: begin
        next_state = ext_bus_pkg::ST_IDLE;
      end
    endcase
  end

  // master state register
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state <= ext_bus_pkg::ST_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // request captured at take for the data cycle
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      cur_fmt        <= ext_bus_pkg::FMT_WORD48;
      cur_write      <= 1'b0;
      cur_cond_false <= 1'b0;
      last_addr      <= ext_bus_pkg::ADDR_ZERO;
      last_valid     <= 1'b0;
    end else if (clk_en && take_req) begin
      cur_fmt        <= req_fmt;
      cur_write      <= req_write;
      cur_cond_false <= req_cond_false;
      last_addr      <= req_addr;
      last_valid     <= 1'b1;
    end
  end

  // output enables follow ownership, dropped the cycle after float
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      addr_oe        <= 1'b0;
      bank_select_oe <= 1'b0;
      page_oe        <= 1'b0;
      rd_n_oe        <= 1'b0;
    end else if (clk_en) begin
      addr_oe        <= pin_drive;
      bank_select_oe <= pin_drive;
      page_oe        <= pin_drive;
      rd_n_oe        <= pin_drive;
    end
  end

  // address pins load only on take
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      addr_out <= ext_bus_pkg::ADDR_ZERO;
    end else if (clk_en && take_req) begin
      addr_out <= req_addr;
    end
  end

  // bank selects move with the address, idle between accesses
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      bank_select_n <= ext_bus_pkg::SEL_IDLE;
    end else if (clk_en) begin
      if (take_req) begin
        bank_select_n <= dec_sel_n;
      end else if (go_idle) begin
        bank_select_n <= ext_bus_pkg::SEL_IDLE;
      end
    end
  end

  // page pulse for one cycle on a bank zero crossing
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      page_cross <= 1'b0;
    end else if (clk_en) begin
      page_cross <= take_req && dec_page;
    end
  end

  // write data pins; enable only for a real write
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      data_out <= ext_bus_pkg::DATA_ZERO;
      data_oe  <= 1'b0;
    end else if (clk_en) begin
      if (take_req) begin
        data_out <= wdata_lanes;
        data_oe  <= req_write && !req_cond_false;
      end else if (floating || go_idle) begin
        data_oe  <= 1'b0;
      end
    end
  end

  // read strobe, held high for writes and failed conditions
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rd_n_out <= 1'b1;
    end else if (clk_en) begin
      if (take_req) begin
        rd_n_out <= req_write || req_cond_false;
      end else if (go_idle && !floating) begin
        rd_n_out <= 1'b1;
      end
    end
  end

  // ready toward the core
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      req_ready <= 1'b0;
    end else if (clk_en) begin
      req_ready <= go_idle && pin_drive;
    end
  end

  // completion pulse and read data, kept until the next read
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= ext_bus_pkg::DATA_ZERO;
    end else if (clk_en) begin
      rsp_valid <= data_cycle;
      if (read_done) begin
        rsp_rdata <= rdata_lanes;
      end
    end
  end

  // slave path: one pulse per strobe low period
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      slv_rd   <= 1'b0;
      slv_addr <= ext_bus_pkg::ADDR_ZERO;
      rd_in_d  <= 1'b0;
    end else if (clk_en) begin
      rd_in_d <= slave_read;
      slv_rd  <= slave_read && !rd_in_d;
      if (slave_read) begin
        slv_addr <= addr_in;
      end
    end
  end
endmodule : shared_external_bus_port

/* ext_mem_model.sv */
// external memory model answering master reads on the data bus
// assumes the read strobe pins of the port under test
`timescale 1ns/10ps
module ext_mem_model #(parameter logic [47:0] PAT = 48'h0000_0000_0000) (
  input  wire logic        ref_clk,
  input  wire logic        rd_n_out,
  input  wire logic        rd_n_oe,
  output logic      [47:0] data_in
);
  logic [47:0] last;
  initial last = 48'h0000_0000_0000;
  // pattern while strobed, inverted junk once released
  always @(posedge ref_clk) last <= data_in;
  assign data_in = (!rd_n_out && rd_n_oe) ? PAT : ~last;
endmodule : ext_mem_model

/* shared_external_bus_port_sva.sv */
// checker for the shared external bus port
// assumes only the top module's ports are visible
`timescale 1ns/10ps
module shared_external_bus_port_sva (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        is_bus_master,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_cond_false,
  input wire logic [31:0] req_addr,
  input wire logic [4:0]  bank_size_log2,
  input wire logic        bus_float_request_n,
  input wire logic        rd_n_in,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        slv_rd,
  input wire logic [31:0] addr_out,
  input wire logic        addr_oe,
  input wire logic        data_oe,
  input wire logic [3:0]  bank_select_n,
  input wire logic        bank_select_oe,
  input wire logic        rd_n_out,
  input wire logic        rd_n_oe,
  input wire logic        page_cross
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // accepted request and the bank select it should produce
  wire        take     = req_valid && req_ready && bus_float_request_n;
  wire [31:0] bank_idx = req_addr >> bank_size_log2;
  wire [3:0]  sel_exp  = (bank_idx < 4) ? 4'(~(4'h1 << bank_idx[1:0])) : 4'hF;
  sel_idle_a: assert property (req_ready |-> bank_select_n == 4'hF)
    else $error("select active while idle");
  resp_lat_a: assert property (take ##1 bus_float_request_n [*2] |=> rsp_valid)
    else $error("response late");
  addr_drive_a: assert property (take |=> addr_out == $past(req_addr) && addr_oe)
    else $error("address not driven");
  sel_decode_a: assert property (take |=> bank_select_n == $past(sel_exp) && bank_select_oe)
    else $error("bank select wrong");
  rd_strobe_a: assert property (take && !req_write && !req_cond_false |=> !rd_n_out && rd_n_oe)
    else $error("read strobe missing");
  float_release_a: assert property (!bus_float_request_n |=> !addr_oe && !data_oe && !bank_select_oe && !rd_n_oe)
    else $error("bus not released");
  slave_quiet_a: assert property (!is_bus_master |=> !addr_oe && !bank_select_oe && !rd_n_oe)
    else $error("slave drives bus");
  page_bank0_a: assert property (page_cross |-> !bank_select_n[0])
    else $error("page pulse outside bank zero");
  slave_read_a: assert property (!is_bus_master && !rd_n_in && $past(rd_n_in) |-> ##[0:2] slv_rd)
    else $error("slave read not seen");
  cover property (take && !req_write);
  cover property (page_cross);
  cover property (slv_rd);
endmodule : shared_external_bus_port_sva
bind shared_external_bus_port shared_external_bus_port_sva shared_external_bus_port_sva_i (.ref_clk, .rstn,
  .is_bus_master, .req_valid, .req_write, .req_cond_false, .req_addr, .bank_size_log2, .bus_float_request_n,
  .rd_n_in, .req_ready, .rsp_valid, .slv_rd, .addr_out, .addr_oe, .data_oe, .bank_select_n, .bank_select_oe,
  .rd_n_out, .rd_n_oe, .page_cross);

/* shared_external_bus_port_bench.sv */
// self-checking bench for the shared external bus port
// assumes the memory model answers reads on the data bus
`timescale 1ns/10ps
module shared_external_bus_port_bench;
  localparam logic [47:0] PAT = 48'hC3A5_96E1_7B2D;
  logic        ref_clk, rstn, clk_en, is_bus_master, req_valid, req_write, req_cond_false;
  logic        bus_float_request_n, rd_n_in, req_ready, rsp_valid, slv_rd, addr_oe, data_oe;
  logic        bank_select_oe, rd_n_out, rd_n_oe, page_cross, page_oe, c1_rd, c1_pg, c1_doe;
  logic [4:0]  bank_size_log2, page_size_log2;
  logic [2:0]  req_fmt;
  logic [3:0]  bank_select_n, c1_sel;
  logic [31:0] req_addr, addr_in, addr_out, slv_addr, c1_addr;
  logic [47:0] req_wdata, data_in, data_out, rsp_rdata, c1_data;
  int          wt, bad_count, n_checks;
  shared_external_bus_port shared_external_bus_port_i (.ref_clk, .rstn, .clk_en, .bank_size_log2,
    .page_size_log2, .is_bus_master, .req_valid, .req_write, .req_cond_false, .req_addr, .req_wdata,
    .req_fmt, .req_ready, .rsp_valid, .rsp_rdata, .slv_rd, .slv_addr, .bus_float_request_n, .addr_in,
    .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .bank_select_n, .bank_select_oe, .rd_n_in,
    .rd_n_out, .rd_n_oe, .page_cross, .page_oe);
  ext_mem_model #(.PAT(PAT)) ext_mem_model_i (.ref_clk, .rd_n_out, .rd_n_oe, .data_in);
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task tmo(input int n);
    if (n >= 40) begin
      bad_count++;
      report_and_stop();
    end
  endtask : tmo
  // lanes of each format, right-aligned
  function automatic logic [47:0] pick(input int f, input logic [47:0] v);
    case (f)
      1: return {16'h0000, v[47:16]};
      2: return {8'h00, v[47:8]};
      3: return {32'h0000_0000, v[31:16]};
      4: return {40'h00_0000_0000, v[23:16]};
      default: return v;
    endcase
  endfunction : pick
  // one master access; snapshot of the address cycle, optional float
  task acc(input logic w, c, fl, input logic [31:0] a, input logic [47:0] d, input logic [2:0] f);
    int n;
    req_valid = 1; req_write = w; req_cond_false = c; req_addr = a; req_wdata = d; req_fmt = f;
    n = 0;
    while (req_ready !== 1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    tmo(n);
    @(negedge ref_clk);
    req_valid = 0;
    c1_sel = bank_select_n; c1_addr = addr_out; c1_data = data_out; c1_rd = rd_n_out; c1_pg = page_cross;
    c1_doe = data_oe;
    wt = 0;
    if (fl) begin
      bus_float_request_n = 0;
      @(negedge ref_clk);
      chk(addr_oe | bank_select_oe | rd_n_oe, 0);
      bus_float_request_n = 1;
      wt = 1;
    end
    while (rsp_valid !== 1 && wt < 40) begin
      @(negedge ref_clk);
      wt++;
    end
    tmo(wt);
  endtask : acc
  task t_lanes;
    for (int f = 0; f < 5; f++) begin
      acc(1, 0, 0, 32'h0000_0040, pick(f, ~PAT), f[2:0]);
      chk(pick(f, c1_data), pick(f, ~PAT));
      chk(c1_doe, 1);
      acc(0, 0, 0, 32'h0000_0044, 48'h0000_0000_0000, f[2:0]);
      chk(rsp_rdata, pick(f, PAT));
      chk(c1_rd, 0);
      chk(c1_doe, 0);
      chk(wt, 2);
    end
  endtask : t_lanes
  task t_banks;
    for (int b = 0; b < 5; b++) begin
      acc(0, b == 2, 0, (b << 13) | 4, 48'h0000_0000_0000, 3'h0);
      chk(c1_addr, (b << 13) | 4);
      chk(c1_sel, b < 4 ? 4'(~(4'h1 << b)) : 4'hF);
      chk(c1_rd, b == 2);
      chk(bank_select_n, 4'hF);
    end
  endtask : t_banks
  task t_page;
    acc(0, 0, 0, 32'h0000_0010, 48'h0000_0000_0000, 3'h0);
    acc(0, 0, 0, 32'h0000_0120, 48'h0000_0000_0000, 3'h0);
    chk(c1_pg, 1);
    chk(page_oe, 1);
    acc(0, 0, 0, 32'h0000_0130, 48'h0000_0000_0000, 3'h0);
    chk(c1_pg, 0);
    acc(0, 0, 0, 32'h0000_2220, 48'h0000_0000_0000, 3'h0);
    chk(c1_pg, 0);
  endtask : t_page
  task t_float;
    acc(0, 0, 1, 32'h0000_0050, 48'h0000_0000_0000, 3'h1);
    chk(wt, 4);
    chk(rsp_rdata, pick(1, PAT));
  endtask : t_float
  task t_slave;
    int n;
    is_bus_master = 0; addr_in = 32'h0000_1A2C; n = 0;
    @(negedge ref_clk);
    chk(addr_oe | bank_select_oe | rd_n_oe | page_oe | data_oe, 0);
    rd_n_in = 0;
    repeat (4) begin
      @(negedge ref_clk);
      n += (slv_rd === 1);
    end
    rd_n_in = 1;
    chk(n, 1);
    chk(slv_addr, 32'h0000_1A2C);
    is_bus_master = 1;
  endtask : t_slave
  initial begin
    clk_en = 1; rstn = 0; is_bus_master = 1; req_valid = 0; req_write = 0; req_cond_false = 0;
    req_addr = 0; req_wdata = 0; req_fmt = 0; bus_float_request_n = 1; rd_n_in = 1; addr_in = 0;
    bank_size_log2 = 5'h0D; page_size_log2 = 5'h08; bad_count = 0; n_checks = 0;
    repeat (16) @(negedge ref_clk);
    chk(bank_select_n, 4'hF);
    rstn = 1;
    t_lanes();
    t_banks();
    t_page();
    t_float();
    t_slave();
    report_and_stop();
  end
endmodule : shared_external_bus_port_bench
